// ==== pchr_cfg_map.svh ====
// Purpose: constants for the configuration header register bank
// Assumes: configuration space addressed by dword index
// Notes: masks mark the bits software may change
`ifndef PCHR_CFG_MAP_SVH
`define PCHR_CFG_MAP_SVH

`define PCHR_IDX_REV_CLASS 6'h02
`define PCHR_IDX_LINE_HDR 6'h03
`define PCHR_IDX_CSR_MEM 6'h04
`define PCHR_IDX_CSR_IO 6'h05
`define PCHR_IDX_FLASH 6'h06
`define PCHR_IDX_SUBSYS 6'h0B
`define PCHR_IDX_BOOT_ROM 6'h0C

`define PCHR_CLASS_VALUE 24'h020000
`define PCHR_HDR_TYPE_VALUE 8'h00
`define PCHR_LINE_SIZE_8 8'h08
`define PCHR_LINE_SIZE_16 8'h10
`define PCHR_LINE_SIZE_RST 8'h00
`define PCHR_TENURE_RST 8'h00

`define PCHR_MEM_BAR_WMASK 32'hFFFFF000
`define PCHR_MEM_BAR_LOW 32'h00000008
`define PCHR_IO_BAR_WMASK 32'hFFFFFFC0
`define PCHR_IO_BAR_LOW 32'h00000001
`define PCHR_FLASH_BAR_WMASK 32'hFFFE0000
`define PCHR_FLASH_BAR_LOW 32'h00000000
`define PCHR_ROM_BAR_WMASK 32'hFFF00000
`define PCHR_ROM_BAR_LOW 32'h00000000
`define PCHR_BAR_RST 32'h00000000

`define PCHR_EE_WORD_CTRL 6'h0A
`define PCHR_EE_WORD_SSID 6'h0B
`define PCHR_EE_WORD_SVID 6'h0C
`define PCHR_EE_SIG_VALID 2'h1
`define PCHR_EE_BOOT_DIS_BIT 11
`define PCHR_EE_REV_LOAD_BIT 13

`endif

// ==== pchr_ee_model.sv ====
// Purpose: serial eeprom word source for the identity autoload
// Assumes: one word per request, answered after lag waiting cycles
// Notes: once released the data lines show the inverse of the last word
`timescale 1ns/100ps

module pchr_ee_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ee_rd_req,
  input wire logic [5:0] ee_rd_addr,
  output logic ee_rd_valid,
  output logic [15:0] ee_rd_data,
  input wire logic [15:0] ctrl_word,
  input wire logic [3:0] lag
);
  logic [3:0] wait_ff;
  logic valid_ff;
  logic [15:0] word_ff;

  function automatic logic [15:0] pick(input logic [5:0] a);
    case (a)
      6'h0A: pick = ctrl_word;
      6'h0B: pick = 16'h5A5A;
      6'h0C: pick = 16'hA5A5;
      default: pick = 16'hFFFF;
    endcase
  endfunction

  // a gap cycle after each pulse: the address only moves on the same edge at which the word is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 4'h0;
      valid_ff <= 1'b0;
      word_ff <= 16'h0000;
    end else if (valid_ff) begin
      valid_ff <= 1'b0;
      wait_ff <= 4'h0;
      word_ff <= ~word_ff;
    end else if (ee_rd_req && wait_ff >= lag) begin
      valid_ff <= 1'b1;
      word_ff <= pick(ee_rd_addr);
    end else if (ee_rd_req) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end

  assign ee_rd_valid = valid_ff;
  assign ee_rd_data = word_ff;
endmodule

// ==== pchr_pkg.sv ====
// Purpose: shared types for the configuration header register bank
// Assumes: nothing beyond the map header
// Notes: constants live in pchr_cfg_map.svh
package pchr_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] idx;
    logic [3:0] be;
    logic [31:0] wdata;
  } pchr_cfg_req_t;

  typedef struct packed {
    logic ack;
    logic retry;
    logic [31:0] rdata;
  } pchr_cfg_rsp_t;

  typedef enum logic [1:0] {
    LD_CTRL = 2'b00,
    LD_SSID = 2'b01,
    LD_SVID = 2'b10,
    LD_DONE = 2'b11
  } pchr_load_state_t;

endpackage

// ==== pchr_regs.sv ====
// Purpose: configuration header registers with eeprom identity load
// Assumes: config accesses and eeprom word reads are synchronous to core_clk
// Notes: every config access is answered one cycle after it is taken
//
// Functional notes
// RULE1: revision byte is read-only; low three bits may come from eeprom.
// RULE2: class reads base class 02, subclass 00, interface 00.
// RULE3: line size accepts only 8 or 16; otherwise no write-and-invalidate.
// RULE4: line size reads zero after any other value is written.
// RULE5: only bit 3 or bit 4 can be set; other bits read zero.
// RULE6: writable bus tenure timer byte limits master ownership in clocks.
// RULE7: header type byte always reads zero, single function.
// RULE8: base register bit 0 reads zero for memory, one for io.
// RULE9: io base register bit 0 one, bit 1 zero, rest address.
// RULE10: memory type field 00 any 32-bit, 01 low, 10 64-bit, 11 reserved.
// RULE11: only bits above the window size are writable; lower read zero.
// RULE12: control/status memory base claims 4 KB prefetchable anywhere in 32-bit.
// RULE13: control/status io base claims 64 bytes in io space.
// RULE14: flash base always claims 128 KB and cannot be disabled.
// RULE15: boot rom base claims 1 MB; reads zero when boot disabled.
// RULE16: after reset read eeprom words Ah, Bh, Ch in that order.
// RULE17: signature not 01 keeps defaults; else load subsystem fields.
// RULE18: signature 01 with bit 13 set loads revision low bits 10:8.
// RULE19: config accesses are retried until the eeprom load completes.
// RULE20: firmware, not the driver, should program the line size.
// RULE21: a retried host must reissue the same access later.
`timescale 1ns/100ps
`include "pchr_cfg_map.svh"

module pchr_regs #(
  // identity defaults: values arbitrary
  parameter logic [7:0] REV_DEFAULT = 8'h3C,
  parameter logic [15:0] SSID_DEFAULT = 16'h1A2B,
  parameter logic [15:0] SVID_DEFAULT = 16'h3C4D
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire pchr_pkg::pchr_cfg_req_t cfg_req,
  output pchr_pkg::pchr_cfg_rsp_t cfg_rsp,
  output logic ee_rd_req,
  output logic [5:0] ee_rd_addr,
  input wire logic ee_rd_valid,
  input wire logic [15:0] ee_rd_data,
  output logic load_done,
  output logic mwi_allowed,
  output logic [7:0] bus_tenure_limit
);

  pchr_pkg::pchr_load_state_t state_ff;
  pchr_pkg::pchr_load_state_t nxt_state;
  logic [15:0] ee_ctrl_ff;
  logic [7:0] revision_identifier_ff;
  logic [15:0] board_product_identifier_ff;
  logic [15:0] board_maker_identifier_ff;
  logic [7:0] line_size_reg_ff;
  logic [7:0] bus_tenure_timer_ff;
  logic [31:0] ctrl_space_memory_base_ff;
  logic [31:0] ctrl_space_io_base_ff;
  logic [31:0] flash_window_base_ff;
  logic [31:0] boot_rom_window_base_ff;
  logic boot_disable_ff;
  logic ack_ff;
  logic retry_ff;
  logic [31:0] rdata_ff;
  logic [31:0] be_mask;
  logic [31:0] rd_value;
  logic take_wr;
  logic take_rd;
  logic sig_valid;

  assign sig_valid = (ee_ctrl_ff[15:14] == `PCHR_EE_SIG_VALID);
  assign load_done = (state_ff == pchr_pkg::LD_DONE);
  assign take_wr = cfg_req.valid && cfg_req.write && load_done;
  assign take_rd = cfg_req.valid && !cfg_req.write && load_done;
  assign be_mask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

  // merge the writable bits of a base register
  function automatic logic [31:0] bar_merge(input logic [31:0] old, input logic [31:0] wmask,
                                            input logic [31:0] wd, input logic [31:0] bm);
    logic [31:0] m;
    m = wmask & bm;
    bar_merge = (old & ~m) | (wd & m);
  endfunction

  // eeprom autoload sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pchr_pkg::LD_CTRL: if (ee_rd_valid) nxt_state = pchr_pkg::LD_SSID;
      pchr_pkg::LD_SSID: if (ee_rd_valid) nxt_state = pchr_pkg::LD_SVID;
      pchr_pkg::LD_SVID: if (ee_rd_valid) nxt_state = pchr_pkg::LD_DONE;
      pchr_pkg::LD_DONE: nxt_state = pchr_pkg::LD_DONE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pchr_pkg::LD_CTRL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // RULE16: word order Ah Bh Ch
  always_comb begin
    ee_rd_req = !load_done;
    unique case (state_ff)
      pchr_pkg::LD_CTRL: ee_rd_addr = `PCHR_EE_WORD_CTRL;
      pchr_pkg::LD_SSID: ee_rd_addr = `PCHR_EE_WORD_SSID;
      pchr_pkg::LD_SVID: ee_rd_addr = `PCHR_EE_WORD_SVID;
      pchr_pkg::LD_DONE: ee_rd_addr = `PCHR_EE_WORD_SVID;
    endcase
  end

  // control word capture; boot disable follows bit 11
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ee_ctrl_ff <= 16'h0000;
      boot_disable_ff <= 1'b0;
    end else if (state_ff == pchr_pkg::LD_CTRL && ee_rd_valid) begin
      ee_ctrl_ff <= ee_rd_data;
      boot_disable_ff <= ee_rd_data[`PCHR_EE_BOOT_DIS_BIT];
    end
  end

  // RULE1: revision low bits override
  // RULE18: only with signature and bit 13
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      revision_identifier_ff <= REV_DEFAULT;
    end else if (state_ff == pchr_pkg::LD_CTRL && ee_rd_valid && ee_rd_data[15:14] == `PCHR_EE_SIG_VALID
                 && ee_rd_data[`PCHR_EE_REV_LOAD_BIT]) begin
      revision_identifier_ff <= {REV_DEFAULT[7:3], ee_rd_data[10:8]};
    end
  end

  // RULE17: subsystem fields only with valid signature
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      board_product_identifier_ff <= SSID_DEFAULT;
      board_maker_identifier_ff <= SVID_DEFAULT;
    end else if (ee_rd_valid && sig_valid) begin
      if (state_ff == pchr_pkg::LD_SSID) begin
        board_product_identifier_ff <= ee_rd_data;
      end
      if (state_ff == pchr_pkg::LD_SVID) begin
        board_maker_identifier_ff <= ee_rd_data;
      end
    end
  end

  // RULE3: only 8 or 16 kept
  // RULE4: other values clear
  // RULE5: only bit 3 or 4
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_size_reg_ff <= `PCHR_LINE_SIZE_RST;
    end else if (take_wr && cfg_req.idx == `PCHR_IDX_LINE_HDR && cfg_req.be[0]) begin
      if (cfg_req.wdata[7:0] == `PCHR_LINE_SIZE_8 || cfg_req.wdata[7:0] == `PCHR_LINE_SIZE_16) begin
        line_size_reg_ff <= cfg_req.wdata[7:0];
      end else begin
        line_size_reg_ff <= `PCHR_LINE_SIZE_RST;
      end
    end
  end

  // RULE3: write-and-invalidate gate
  assign mwi_allowed = (line_size_reg_ff != `PCHR_LINE_SIZE_RST);

  // RULE6: tenure timer fully writable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_tenure_timer_ff <= `PCHR_TENURE_RST;
    end else if (take_wr && cfg_req.idx == `PCHR_IDX_LINE_HDR && cfg_req.be[1]) begin
      bus_tenure_timer_ff <= cfg_req.wdata[15:8];
    end
  end

  assign bus_tenure_limit = bus_tenure_timer_ff;

  // RULE11: only upper window bits writable
  // RULE14: flash window never disabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_space_memory_base_ff <= `PCHR_BAR_RST;
      ctrl_space_io_base_ff <= `PCHR_BAR_RST;
      flash_window_base_ff <= `PCHR_BAR_RST;
      boot_rom_window_base_ff <= `PCHR_BAR_RST;
    end else if (take_wr) begin
      if (cfg_req.idx == `PCHR_IDX_CSR_MEM) begin
        ctrl_space_memory_base_ff <= bar_merge(ctrl_space_memory_base_ff, `PCHR_MEM_BAR_WMASK, cfg_req.wdata,
                                               be_mask);
      end
      if (cfg_req.idx == `PCHR_IDX_CSR_IO) begin
        ctrl_space_io_base_ff <= bar_merge(ctrl_space_io_base_ff, `PCHR_IO_BAR_WMASK, cfg_req.wdata, be_mask);
      end
      if (cfg_req.idx == `PCHR_IDX_FLASH) begin
        flash_window_base_ff <= bar_merge(flash_window_base_ff, `PCHR_FLASH_BAR_WMASK, cfg_req.wdata, be_mask);
      end
      if (cfg_req.idx == `PCHR_IDX_BOOT_ROM && !boot_disable_ff) begin
        boot_rom_window_base_ff <= bar_merge(boot_rom_window_base_ff, `PCHR_ROM_BAR_WMASK, cfg_req.wdata,
                                             be_mask);
      end
    end
  end

  // read mux; unmapped dwords read zero
  always_comb begin
    rd_value = 32'h00000000;
    unique case (cfg_req.idx)
      // RULE1: revision byte
      // RULE2: class fields
      `PCHR_IDX_REV_CLASS: rd_value = {`PCHR_CLASS_VALUE, revision_identifier_ff};
      // RULE7: header type zero
      `PCHR_IDX_LINE_HDR: rd_value = {8'h00, `PCHR_HDR_TYPE_VALUE, bus_tenure_timer_ff, line_size_reg_ff};
      // RULE8: memory bit 0 zero
      // RULE10: type 00 any 32-bit
      // RULE12: 4 KB prefetchable
      `PCHR_IDX_CSR_MEM: rd_value = (ctrl_space_memory_base_ff & `PCHR_MEM_BAR_WMASK) | `PCHR_MEM_BAR_LOW;
      // RULE9: io bit 0 one, bit 1 zero
      // RULE13: 64 byte io window
      `PCHR_IDX_CSR_IO: rd_value = (ctrl_space_io_base_ff & `PCHR_IO_BAR_WMASK) | `PCHR_IO_BAR_LOW;
      // RULE14: 128 KB flash
      `PCHR_IDX_FLASH: rd_value = (flash_window_base_ff & `PCHR_FLASH_BAR_WMASK) | `PCHR_FLASH_BAR_LOW;
      `PCHR_IDX_SUBSYS: rd_value = {board_product_identifier_ff, board_maker_identifier_ff};
      // RULE15: 1 MB rom, zero when disabled
      `PCHR_IDX_BOOT_ROM: rd_value = boot_disable_ff ? 32'h00000000 :
                                     ((boot_rom_window_base_ff & `PCHR_ROM_BAR_WMASK) | `PCHR_ROM_BAR_LOW);
      default: rd_value = 32'h00000000;
    endcase
  end

  // RULE19: retry until load done
  // a retried access leaves no side effect, so the host can simply reissue it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      retry_ff <= 1'b0;
    end else begin
      ack_ff <= cfg_req.valid && load_done;
      retry_ff <= cfg_req.valid && !load_done;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (take_rd) begin
      rdata_ff <= rd_value;
    end
  end

  assign cfg_rsp.ack = ack_ff;
  assign cfg_rsp.retry = retry_ff;
  assign cfg_rsp.rdata = rdata_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [5:0] i);
    take_rd && cfg_req.idx == i;
  endsequence

  sequence s_bad_line_wr;
    take_wr && cfg_req.idx == `PCHR_IDX_LINE_HDR && cfg_req.be[0] &&
      cfg_req.wdata[7:0] != `PCHR_LINE_SIZE_8 && cfg_req.wdata[7:0] != `PCHR_LINE_SIZE_16;
  endsequence

  sequence s_ctrl_word_in;
    state_ff == pchr_pkg::LD_CTRL && ee_rd_valid;
  endsequence

  sequence s_wr(logic [5:0] i);
    take_wr && cfg_req.idx == i;
  endsequence

  sequence s_good_line_wr;
    take_wr && cfg_req.idx == `PCHR_IDX_LINE_HDR && cfg_req.be[0] &&
      (cfg_req.wdata[7:0] == `PCHR_LINE_SIZE_8 || cfg_req.wdata[7:0] == `PCHR_LINE_SIZE_16);
  endsequence

  // one word of the autoload taken while the sequencer sits in a given step
  sequence s_ee_word(pchr_pkg::pchr_load_state_t st);
    state_ff == st && ee_rd_valid;
  endsequence

  AST_RETRY_BEFORE_LOAD: assert property (cfg_req.valid && !load_done |=> cfg_rsp.retry && !cfg_rsp.ack) // RULE19
    else $error("access before load not retried");
  AST_ACK_AFTER_LOAD: assert property (cfg_req.valid && load_done |=> cfg_rsp.ack && !cfg_rsp.retry)
    else $error("access after load not acknowledged");
  AST_LINE_SIZE_LEGAL: assert property (line_size_reg_ff == 8'h00 || line_size_reg_ff == 8'h08 // RULE5
                                        || line_size_reg_ff == 8'h10)
    else $error("line size holds an illegal value");
  AST_LINE_SIZE_BAD_WRITE: assert property (s_bad_line_wr |=> line_size_reg_ff == 8'h00) // RULE4
    else $error("illegal line size not cleared");
  AST_MWI_BLOCKED: assert property (s_bad_line_wr |=> !mwi_allowed) // RULE3
    else $error("write-and-invalidate left enabled");
  AST_CLASS_READ: assert property (s_rd(6'h02) |=> cfg_rsp.rdata[31:8] == 24'h020000) // RULE2
    else $error("class code wrong");
  AST_HDR_TYPE: assert property (s_rd(6'h03) |=> cfg_rsp.rdata[23:16] == 8'h00) // RULE7
    else $error("header type not zero");
  AST_MEM_BAR_LOW: assert property (s_rd(6'h04) |=> cfg_rsp.rdata[11:0] == 12'h008) // RULE12
    else $error("memory base low bits wrong");
  AST_IO_BAR_LOW: assert property (s_rd(6'h05) |=> cfg_rsp.rdata[5:0] == 6'h01) // RULE9
    else $error("io base low bits wrong");
  AST_FLASH_BAR_LOW: assert property (s_rd(6'h06) |=> cfg_rsp.rdata[16:0] == 17'h00000) // RULE14
    else $error("flash base low bits wrong");
  AST_ROM_DISABLED: assert property (boot_disable_ff && take_rd && cfg_req.idx == 6'h0C // RULE15
                                     |=> cfg_rsp.rdata == 32'h00000000)
    else $error("disabled boot rom base not zero");
  AST_EE_ORDER: assert property (s_ctrl_word_in |=> ee_rd_addr == 6'h0B && ee_rd_req) // RULE16
    else $error("eeprom word order wrong");
  AST_REV_KEEP: assert property (s_ctrl_word_in and (ee_rd_data[15:14] != 2'h1) // RULE17
                                 |=> revision_identifier_ff == $past(revision_identifier_ff))
    else $error("revision changed without signature");

  // a refused access must leave no trace, or a reissued write could land twice
  AST_RSP_EXCLUSIVE: assert property (!(cfg_rsp.ack && cfg_rsp.retry)) // RULE19
    else $error("ack and retry together");
  AST_RETRY_NO_EFFECT: assert property (cfg_req.valid && !load_done // RULE19
                                        |=> $stable(line_size_reg_ff) && $stable(bus_tenure_timer_ff)
                                            && $stable(ctrl_space_memory_base_ff) && $stable(flash_window_base_ff))
    else $error("retried access changed a register");
  AST_LOAD_CAUSE: assert property ($rose(load_done) // RULE19
                                   |-> $past(state_ff == pchr_pkg::LD_SVID && ee_rd_valid))
    else $error("load finished without the third word");

  AST_EE_ORDER_LAST: assert property (s_ee_word(pchr_pkg::LD_SSID) |=> ee_rd_addr == 6'h0C && ee_rd_req) // RULE16
    else $error("eeprom third word not requested");
  AST_LOAD_FINISH: assert property (s_ee_word(pchr_pkg::LD_SVID) |=> load_done && !ee_rd_req) // RULE16
    else $error("eeprom load not finished after third word");

  AST_REV_LOAD: assert property (s_ee_word(pchr_pkg::LD_CTRL) ##0 ee_rd_data[15:13] == 3'h3 // RULE18
                                 |=> revision_identifier_ff == {REV_DEFAULT[7:3], $past(ee_rd_data[10:8])})
    else $error("revision low bits not loaded");
  AST_SSID_LOAD: assert property (s_ee_word(pchr_pkg::LD_SSID) ##0 sig_valid // RULE17
                                  |=> board_product_identifier_ff == $past(ee_rd_data))
    else $error("board_product_identifier not loaded");
  AST_SVID_LOAD: assert property (s_ee_word(pchr_pkg::LD_SVID) ##0 sig_valid // RULE17
                                  |=> board_maker_identifier_ff == $past(ee_rd_data))
    else $error("board_maker_identifier not loaded");
  AST_SUBSYS_DEFAULT: assert property (load_done && !sig_valid // RULE17
                                       |-> board_product_identifier_ff == SSID_DEFAULT
                                           && board_maker_identifier_ff == SVID_DEFAULT)
    else $error("subsystem defaults lost without signature");

  AST_REV_READ_ONLY: assert property (s_wr(6'h02) |=> $stable(revision_identifier_ff)) // RULE1
    else $error("revision changed by a write");
  AST_REV_READ: assert property (s_rd(6'h02) |=> cfg_rsp.rdata[7:0] == $past(revision_identifier_ff)) // RULE1
    else $error("revision read wrong");
  AST_HDR_UPPER: assert property (s_rd(6'h03) |=> cfg_rsp.rdata[31:24] == 8'h00) // RULE7
    else $error("header dword upper byte not zero");

  AST_LINE_SIZE_KEPT: assert property (s_good_line_wr // RULE3
                                       |=> line_size_reg_ff == $past(cfg_req.wdata[7:0]) && mwi_allowed)
    else $error("legal line size not kept");
  AST_TENURE_WRITE: assert property (s_wr(6'h03) ##0 cfg_req.be[1] // RULE6
                                     |=> bus_tenure_limit == $past(cfg_req.wdata[15:8]))
    else $error("tenure timer write lost");
  AST_TENURE_HOLD: assert property (!(take_wr && cfg_req.idx == 6'h03 && cfg_req.be[1]) // RULE6
                                    |=> $stable(bus_tenure_limit))
    else $error("tenure timer changed without a write");

  AST_MEM_BAR_SPACE: assert property (s_rd(6'h04) |=> cfg_rsp.rdata[2:0] == 3'h0) // RULE10
    else $error("memory base space or type bits wrong");
  AST_IO_BAR_SPACE: assert property (s_rd(6'h05) |=> cfg_rsp.rdata[1:0] == 2'h1) // RULE8
    else $error("io base space bits wrong");
  AST_MEM_BAR_WRITE: assert property (s_wr(6'h04) ##0 cfg_req.be == 4'hF // RULE12
                                      |=> ctrl_space_memory_base_ff[31:12] == $past(cfg_req.wdata[31:12]))
    else $error("memory base address bits not written");
  AST_IO_BAR_WRITE: assert property (s_wr(6'h05) ##0 cfg_req.be == 4'hF // RULE13
                                     |=> ctrl_space_io_base_ff[31:6] == $past(cfg_req.wdata[31:6]))
    else $error("io base address bits not written");
  AST_FLASH_BAR_WRITE: assert property (s_wr(6'h06) ##0 cfg_req.be == 4'hF // RULE11
                                        |=> flash_window_base_ff[31:17] == $past(cfg_req.wdata[31:17]))
    else $error("flash base address bits not written");

  AST_ROM_WRITE_BLOCKED: assert property (s_wr(6'h0C) ##0 boot_disable_ff // RULE15
                                          |=> $stable(boot_rom_window_base_ff))
    else $error("disabled boot rom base written");
  AST_ROM_BAR_LOW: assert property (s_rd(6'h0C) ##0 !boot_disable_ff // RULE11
                                    |=> cfg_rsp.rdata[19:0] == 20'h00000)
    else $error("boot rom base low bits not zero");

endmodule

// ==== pci_config_header_regs_test.sv ====
// Purpose: self-checking bench for the configuration header registers
// Assumes: config host drives at the falling edge; eeprom model answers
// Notes: three autoload images are tried, each after a fresh reset
`timescale 1ns/100ps

module pci_config_header_regs_test;
  localparam logic [7:0] REV_DEF = 8'h3C;
  localparam logic [15:0] SSID_DEF = 16'h1A2B;
  localparam logic [15:0] SVID_DEF = 16'h3C4D;
  localparam logic [15:0] CTRL [3] = '{16'hAF00, 16'h4700, 16'h6500};
  localparam logic [3:0] LAG [3] = '{4'h3, 4'h1, 4'h0};
  localparam logic [31:0] LS_WR [4] = '{32'h00FF5A08, 32'hFFFFA510, 32'h00000007, 32'hFFFFFFFF};
  localparam logic [31:0] LS_RD [4] = '{32'h00005A08, 32'h0000A510, 32'h00000000, 32'h0000FF00};
  localparam logic [5:0] BAR_IDX [4] = '{6'h04, 6'h05, 6'h06, 6'h0C};
  localparam logic [31:0] BAR_ONES [4] = '{32'hFFFFF008, 32'hFFFFFFC1, 32'hFFFE0000, 32'hFFF00000};
  localparam logic [31:0] BAR_ZERO [4] = '{32'h00000008, 32'h00000001, 32'h00000000, 32'h00000000};

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  pchr_pkg::pchr_cfg_req_t req = '0;
  pchr_pkg::pchr_cfg_rsp_t rsp;
  logic ee_rd_req, ee_rd_valid, load_done, mwi_allowed, refused;
  logic [5:0] ee_rd_addr;
  logic [15:0] ee_rd_data;
  logic [7:0] bus_tenure_limit;
  logic [15:0] ctrl_word = 16'h0000;
  logic [3:0] lag = 4'h0;
  logic [31:0] rd, exp_v;
  logic sig_ok;
  logic [5:0] ee_q [$];
  int num_errors = 0;
  int checks = 0;

  always #2.5 core_clk = ~core_clk;

  pchr_regs #(.REV_DEFAULT(REV_DEF), .SSID_DEFAULT(SSID_DEF), .SVID_DEFAULT(SVID_DEF)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_req(req), .cfg_rsp(rsp), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data),
    .load_done(load_done), .mwi_allowed(mwi_allowed), .bus_tenure_limit(bus_tenure_limit));

  pchr_ee_model ee_model (
    .core_clk(core_clk), .rst_n(rst_n), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
    .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data), .ctrl_word(ctrl_word), .lag(lag));

  // words taken by the design, in order
  always @(posedge core_clk) begin
    if (rst_n && ee_rd_valid && !load_done) begin
      ee_q.push_back(ee_rd_addr);
    end
  end

  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access, entered at a falling edge; a spare cycle keeps valid from being set twice at once
  task automatic cfg_xfer(input logic w, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    int n;
    n = 0;
    req = '{valid: 1'b1, write: w, idx: idx, be: be, wdata: wd};
    @(posedge core_clk);
    @(negedge core_clk);
    req.valid = 1'b0;
    while (rsp.ack !== 1'b1 && rsp.retry !== 1'b1 && n < 3) begin
      @(negedge core_clk);
      n++;
    end
    refused = (rsp.retry === 1'b1) || (rsp.ack !== 1'b1);
    rd = rsp.rdata;
    @(negedge core_clk);
  endtask

  task automatic cfg(input logic w, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    int t;
    t = 0;
    do begin
      cfg_xfer(w, idx, be, wd);
      t++;
    end while (refused && t < 40);
    check({31'h0, refused}, 32'h0);
  endtask

  initial begin
    #50000;
    num_errors++;
    test_done();
  end

  initial begin
    for (int r = 0; r < 3; r++) begin
      rst_n = 1'b0;
      ctrl_word = CTRL[r];
      lag = LAG[r];
      ee_q.delete();
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      cfg_xfer(1'b1, 6'h03, 4'hF, 32'h00000008);
      check({31'h0, refused}, 32'h1);
      for (int n = 0; n < 200 && load_done !== 1'b1; n++) @(negedge core_clk);
      check(32'(ee_q.size()), 32'h3);
      for (int i = 0; i < 3 && i < ee_q.size(); i++) check({26'h0, ee_q[i]}, 32'h0A + i);
      cfg(1'b0, 6'h03, 4'hF, 32'h0);
      check(rd, 32'h00000000);
      sig_ok = (CTRL[r][15:14] == 2'b01);
      exp_v = {24'h020000, (sig_ok && CTRL[r][13]) ? {REV_DEF[7:3], CTRL[r][10:8]} : REV_DEF};
      cfg(1'b0, 6'h02, 4'hF, 32'h0);
      check(rd, exp_v);
      cfg(1'b1, 6'h02, 4'hF, 32'hFFFFFFFF);
      cfg(1'b0, 6'h02, 4'hF, 32'h0);
      check(rd, exp_v);
      cfg(1'b0, 6'h0B, 4'hF, 32'h0);
      check(rd, sig_ok ? 32'h5A5AA5A5 : {SSID_DEF, SVID_DEF});
      cfg(1'b1, 6'h0C, 4'hF, 32'hFFFFFFFF);
      cfg(1'b0, 6'h0C, 4'hF, 32'h0);
      check(rd, CTRL[r][11] ? 32'h00000000 : 32'hFFF00000);
      cfg(1'b1, 6'h06, 4'hF, 32'hFFFFFFFF);
      cfg(1'b0, 6'h06, 4'hF, 32'h0);
      check(rd, 32'hFFFE0000);
    end
    // line size set only by this setup code, as firmware would
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, 6'h03, 4'hF, LS_WR[i]);
      cfg(1'b0, 6'h03, 4'hF, 32'h0);
      check(rd, LS_RD[i]);
      check({31'h0, mwi_allowed}, (i < 2) ? 32'h1 : 32'h0);
      check({24'h0, bus_tenure_limit}, {24'h0, LS_RD[i][15:8]});
    end
    cfg(1'b1, 6'h03, 4'h2, 32'hFFFF3C10);
    cfg(1'b0, 6'h03, 4'hF, 32'h0);
    check(rd, 32'h00003C00);
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, BAR_IDX[i], 4'hF, 32'hFFFFFFFF);
      cfg(1'b0, BAR_IDX[i], 4'hF, 32'h0);
      check(rd, BAR_ONES[i]);
      cfg(1'b1, BAR_IDX[i], 4'hF, 32'h00000000);
      cfg(1'b0, BAR_IDX[i], 4'hF, 32'h0);
      check(rd, BAR_ZERO[i]);
    end
    cfg(1'b1, 6'h3F, 4'hF, 32'hFFFFFFFF);
    cfg(1'b0, 6'h3F, 4'hF, 32'h0);
    check(rd, 32'h00000000);
    test_done();
  end
endmodule
